// File: logic/tear_scan_params.svh
// constants for the tear output and gate scan block
// assumes a 50 MHz system clock; included by bare name
`ifndef TEAR_SCAN_PARAMS_SVH
`define TEAR_SCAN_PARAMS_SVH
`define CLK_NS 20
`define CLK_MHZ 50
`define GATE_LINES 320
`define LINE_NS 48000
`define HBLANK_NS 8000
`define VBLANK_US 1100
`define TEAR_VHIGH_MIN_US 1000
`define TEAR_HHIGH_MAX_US 500
`define LINE_CYC (`LINE_NS / `CLK_NS)
`define HBLANK_CYC (`HBLANK_NS / `CLK_NS)
`define VBLANK_CYC (`VBLANK_US * `CLK_MHZ)
`define VHIGH_MIN_CYC ((`TEAR_VHIGH_MIN_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define HHIGH_MAX_CYC (`TEAR_HHIGH_MAX_US * `CLK_MHZ)
`define OP_TEAR_OFF 8'h34
`define OP_TEAR_ON 8'h35
`define TEAR_MODE_BIT 0
`define CFG_REVERSE_BIT 0
`define CFG_INTERLACE_BIT 1
`define REG_CMD 8'h00
`define REG_SCAN 8'h04
`define REG_STATUS 8'h08
`define STAT_VBLANK_BIT 16
`define STAT_TEAR_BIT 17
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: logic/tear_scan_pkg.sv
// types for the tear output and gate scan block
// no dependencies
package tear_scan_pkg;
    typedef enum logic [1:0] {
        PH_VBLANK = 2'h1,
        PH_ACTIVE = 2'h2
    } phase_t;
endpackage

// File: logic/tear_sync_and_gate_scan.sv
// tear sync output, gate line scan sequencer and axi4-lite registers
// assumes one 50 MHz clock; bus master on the same clock
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "tear_scan_params.svh"

module tear_sync_and_gate_scan #(
    parameter int GATES = `GATE_LINES,
    parameter int LINE_CYC = `LINE_CYC,
    parameter int HBLANK_CYC = `HBLANK_CYC,
    parameter int VBLANK_CYC = `VBLANK_CYC,
    parameter int CNT_W = 17
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_tear_sync_out,
    output logic [GATES-1:0] o_gate_select
);
    localparam logic [CNT_W-1:0] VB_LAST = CNT_W'(VBLANK_CYC - 1);
    localparam logic [CNT_W-1:0] LN_LAST = CNT_W'(LINE_CYC - 1);
    localparam logic [CNT_W-1:0] HB_CYC = CNT_W'(HBLANK_CYC);
    localparam logic [8:0] LAST_LINE = 9'(GATES - 1);
    localparam logic [8:0] HALF = 9'(GATES / 2);
    localparam int VH_MIN = (`VHIGH_MIN_CYC < VBLANK_CYC - 1) ? `VHIGH_MIN_CYC : VBLANK_CYC - 1;
    localparam int HH_MAX = `HHIGH_MAX_CYC;

    // bus state
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic tear_en_ff, tear_mode_ff, reverse_ff, interlace_ff;
    logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
    logic [7:0] nxt_awaddr;
    logic [31:0] nxt_wdata, nxt_rdata;
    logic [3:0] nxt_wstrb;
    logic [1:0] nxt_bresp, nxt_rresp;
    logic nxt_tear_en, nxt_tear_mode, nxt_reverse, nxt_interlace;
    logic do_wr, cmd_hit;
    logic [7:0] wr_word, rd_word;

    // scan state
    tear_scan_pkg::phase_t phase_ff, nxt_phase;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [8:0] line_ff, nxt_line, base_idx, gate_idx;
    logic [1:0] cfg_ff, nxt_cfg;
    logic tear_ff, nxt_tear, hblank, update;
    logic [GATES-1:0] gate_ff, nxt_gate;

    assign o_awready = !aw_got_ff && !bvalid_ff;
    assign o_wready = !w_got_ff && !bvalid_ff;
    assign o_arready = !rvalid_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_tear_sync_out = tear_ff;
    assign o_gate_select = gate_ff;

    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_word = {awaddr_ff[7:2], 2'h0};
    assign rd_word = {i_araddr[7:2], 2'h0};
    assign cmd_hit = do_wr && wr_word == `REG_CMD && wstrb_ff[0];

    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_tear_en = tear_en_ff;
        nxt_tear_mode = tear_mode_ff;
        nxt_reverse = reverse_ff;
        nxt_interlace = interlace_ff;
        if (i_awvalid && o_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = i_wdata;
            nxt_wstrb = i_wstrb;
        end
        if (bvalid_ff && i_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = `RESP_OKAY;
            case (wr_word)
                `REG_CMD: begin
                    // unknown opcodes are dropped silently, as a command port would
                    if (cmd_hit && wdata_ff[7:0] == `OP_TEAR_OFF) begin
                        nxt_tear_en = 1'b0;
                    end else if (cmd_hit && wdata_ff[7:0] == `OP_TEAR_ON && wstrb_ff[1]) begin
                        nxt_tear_en = 1'b1;
                        nxt_tear_mode = wdata_ff[8 + `TEAR_MODE_BIT];
                    end
                end
                `REG_SCAN: begin
                    if (wstrb_ff[0]) begin
                        nxt_reverse = wdata_ff[`CFG_REVERSE_BIT];
                        nxt_interlace = wdata_ff[`CFG_INTERLACE_BIT];
                    end
                end
                `REG_STATUS: begin
                end
                default: nxt_bresp = `RESP_SLVERR;
            endcase
        end
        if (rvalid_ff && i_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `RESP_OKAY;
            nxt_rdata = 32'h0;
            case (rd_word)
                `REG_CMD: nxt_rdata[1:0] = {tear_mode_ff, tear_en_ff};
                `REG_SCAN: nxt_rdata[1:0] = {interlace_ff, reverse_ff};
                `REG_STATUS: begin
                    nxt_rdata[8:0] = line_ff;
                    nxt_rdata[`STAT_VBLANK_BIT] = phase_ff == tear_scan_pkg::PH_VBLANK;
                    nxt_rdata[`STAT_TEAR_BIT] = tear_ff;
                end
                default: nxt_rresp = `RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'h0;
            tear_en_ff <= 1'b0;
            tear_mode_ff <= 1'b0;
            reverse_ff <= 1'b0;
            interlace_ff <= 1'b0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            tear_en_ff <= nxt_tear_en;
            tear_mode_ff <= nxt_tear_mode;
            reverse_ff <= nxt_reverse;
            interlace_ff <= nxt_interlace;
        end
    end

    // line = hblank head then update; field = 320 lines then vblank
    assign hblank = phase_ff == tear_scan_pkg::PH_ACTIVE && cnt_ff < HB_CYC;
    assign update = phase_ff == tear_scan_pkg::PH_ACTIVE && !hblank;

    always_comb begin
        nxt_phase = phase_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_line = line_ff;
        nxt_cfg = cfg_ff;
        case (phase_ff)
            tear_scan_pkg::PH_VBLANK: begin
                if (cnt_ff == VB_LAST) begin
                    nxt_phase = tear_scan_pkg::PH_ACTIVE;
                    nxt_cnt = '0;
                    nxt_line = 9'h000;
                    // order only changes at field start, so no frame mixes two orders
                    nxt_cfg = {interlace_ff, reverse_ff};
                end
            end
            tear_scan_pkg::PH_ACTIVE: begin
                if (cnt_ff == LN_LAST) begin
                    nxt_cnt = '0;
                    if (line_ff == LAST_LINE) begin
                        nxt_phase = tear_scan_pkg::PH_VBLANK;
                    end else begin
                        nxt_line = line_ff + 9'h001;
                    end
                end
            end
            default: begin
                nxt_phase = tear_scan_pkg::PH_VBLANK;
                nxt_cnt = '0;
            end
        endcase
        nxt_tear = 1'b0;
        if (tear_en_ff) begin
            if (phase_ff == tear_scan_pkg::PH_VBLANK) begin
                // in horizontal mode one low cycle ends vblank so the first h pulse stays separate
                nxt_tear = tear_mode_ff ? cnt_ff != VB_LAST : 1'b1;
            end else begin
                nxt_tear = tear_mode_ff && hblank;
            end
        end
        if (!cfg_ff[1]) begin
            base_idx = line_ff;
        end else if (line_ff < HALF) begin
            base_idx = {line_ff[7:0], 1'b0};
        end else begin
            base_idx = {8'(line_ff - HALF), 1'b1};
        end
        gate_idx = cfg_ff[0] ? LAST_LINE - base_idx : base_idx;
    end

    genvar g;
    generate
        for (g = 0; g < GATES; g++) begin : gen_gate
            assign nxt_gate[g] = update && gate_idx == 9'(g);
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_ff <= tear_scan_pkg::PH_VBLANK;
            cnt_ff <= '0;
            line_ff <= 9'h000;
            cfg_ff <= 2'h0;
            tear_ff <= 1'b0;
            gate_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
            line_ff <= nxt_line;
            cfg_ff <= nxt_cfg;
            tear_ff <= nxt_tear;
            gate_ff <= nxt_gate;
        end
    end

    // checking helpers
    logic [CNT_W-1:0] hi_run_ff;
    logic seen_ff;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_run_ff <= '0;
            seen_ff <= 1'b0;
        end else begin
            hi_run_ff <= tear_ff ? hi_run_ff + CNT_W'(1) : '0;
            if (!tear_en_ff || tear_mode_ff) begin
                seen_ff <= 1'b0;
            end else if (nxt_phase == tear_scan_pkg::PH_VBLANK && phase_ff == tear_scan_pkg::PH_ACTIVE) begin
                seen_ff <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    tear_off_low_a: assert property (!tear_en_ff |=> !o_tear_sync_out)
        else $error("tear output high while disabled");
    cmd_off_a: assert property (cmd_hit && wdata_ff[7:0] == `OP_TEAR_OFF |=> ##1 !o_tear_sync_out)
        else $error("tear off command not obeyed");
    mode_hold_a: assert property ($changed(tear_mode_ff) |-> $past(cmd_hit))
        else $error("tear mode changed without command");
    vmode_level_a: assert property (tear_en_ff && !tear_mode_ff && $stable(tear_en_ff) && $stable(tear_mode_ff)
        |-> o_tear_sync_out == ($past(phase_ff) == tear_scan_pkg::PH_VBLANK))
        else $error("vertical tear level wrong");
    vhigh_min_a: assert property (seen_ff && $fell(o_tear_sync_out) |-> hi_run_ff >= CNT_W'(VH_MIN))
        else $error("vertical high phase too short");
    hhigh_max_a: assert property (tear_mode_ff && o_tear_sync_out && phase_ff == tear_scan_pkg::PH_ACTIVE
        |-> hi_run_ff < CNT_W'(HH_MAX))
        else $error("horizontal high phase too long");
    one_gate_a: assert property ($onehot0(o_gate_select))
        else $error("gate select not one-hot");
    gate_on_a: assert property (update |=> o_gate_select != '0) else $error("no gate selected during update");
    seq_fwd_a: assert property ($past(update) && cfg_ff == 2'h0 && $stable(cfg_ff)
        |-> o_gate_select[$past(line_ff)])
        else $error("sequential forward order wrong");
    seq_rev_a: assert property ($past(update) && cfg_ff == 2'h1 && $stable(cfg_ff)
        |-> o_gate_select[LAST_LINE - $past(line_ff)])
        else $error("reversed order wrong");
    odd_first_a: assert property ($past(update) && cfg_ff == 2'h2 && $stable(cfg_ff) && $past(line_ff) < HALF
        |-> o_gate_select[{$past(line_ff[7:0]), 1'b0}])
        else $error("odd-first order wrong");
    even_first_a: assert property ($past(update) && cfg_ff == 2'h3 && $stable(cfg_ff) && $past(line_ff) < HALF
        |-> o_gate_select[LAST_LINE - {$past(line_ff[7:0]), 1'b0}])
        else $error("even-first reversed order wrong");

    vpulse_c: cover property (seen_ff && $fell(o_tear_sync_out));
    hpulse_c: cover property (tear_mode_ff && phase_ff == tear_scan_pkg::PH_ACTIVE && $rose(o_tear_sync_out));
    both_bits_c: cover property (cfg_ff == 2'h3 && update);
    write_resp_c: cover property (o_bvalid && i_bready);
endmodule

// File: verif/host_sync_model.sv
// host model: watches the tear output and opens its write window
// assumes one clock shared with the block; min_high sets the run length
`timescale 1ns/100ps
module host_sync_model #(
    parameter int MIN_HIGH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_tear,
    output logic o_write_ok
);
    int run_ff;
    int nxt_run;
    logic nxt_write_ok;
    // short line pulses are too brief for a whole frame write
    always_comb begin
        nxt_run = i_tear ? run_ff + 1 : 0;
        nxt_write_ok = i_tear && (run_ff >= MIN_HIGH);
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            run_ff <= 0;
            o_write_ok <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            o_write_ok <= nxt_write_ok;
        end
    end
endmodule

// File: verif/tear_sync_and_gate_scan_test.sv
// self-checking bench: register bus, gate scan orders, tear output modes
// assumes short line and blank counts so several fields fit the run
`timescale 1ns/100ps
`include "tear_scan_params.svh"
module tear_sync_and_gate_scan_test;
    localparam int LC = 20;
    localparam int HB = 5;
    localparam int VB = 60;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tear, write_ok;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [319:0] gates;
    logic [319:0] prev_g = 320'h0;
    logic [319:0] gq[$];
    int tq[$];
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int err_count = 0, checked = 0, t_len = 0, seed = 25680;
    logic t_arm = 1'b0, watch_g = 1'b0, watch_t = 1'b0;

    always #10 i_clk = ~i_clk;

    tear_sync_and_gate_scan #(.LINE_CYC(LC), .HBLANK_CYC(HB), .VBLANK_CYC(VB)) i_tear_sync_and_gate_scan (
        .i_clk(i_clk), .i_resetn(i_resetn),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_tear_sync_out(tear), .o_gate_select(gates));
    host_sync_model #(.MIN_HIGH(8)) i_host_sync_model (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_tear(tear), .o_write_ok(write_ok));

    task automatic check(input string what, input logic [319:0] exp, input logic [319:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic timed_out(input int n, input int lim);
        if (n >= lim) begin
            err_count++;
            $display("unexpected wait: bound %0d seen %0d", lim, n);
            test_done();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        n = 0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        timed_out(n, 200);
        @(posedge i_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        timed_out(n, 200);
        @(posedge i_clk);
    endtask

    // hblank is short, so a long gap without gates means vertical blank
    task automatic wait_vblank();
        int z, n;
        z = 0;
        n = 0;
        while (z < 10 && n < 20000) begin
            @(posedge i_clk);
            n++;
            z = (gates === 320'h0) ? z + 1 : 0;
        end
        timed_out(n, 20000);
    endtask

    task automatic wait_empty();
        int n;
        for (n = 0; n < 20000 && (gq.size() > 0 || tq.size() > 0); n++) @(posedge i_clk);
        timed_out(n, 20000);
    endtask

    always @(posedge i_clk) begin
        if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) check("bresp", 320'(bq.pop_front()), 320'(bresp));
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) check("read", 320'(rq.pop_front()), 320'({rresp, rdata}));
        if (watch_g && gates !== 320'h0 && gates !== prev_g && gq.size() > 0) check("gate", gq.pop_front(), gates);
        prev_g <= gates;
        if (tear === 1'b1) begin
            if (t_len == 0) t_arm <= watch_t;
            t_len <= t_len + 1;
        end else begin
            if (t_arm && t_len > 0 && tq.size() > 0) check("tear_high", 320'(tq.pop_front()), 320'(t_len));
            t_arm <= 1'b0;
            t_len <= 0;
        end
    end

    initial begin
        int n, il, c;
        logic [1:0] cfg;
        logic [31:0] rnd;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        check("tear_reset", 320'h0, 320'(tear));
        check("gates_reset", 320'h0, gates);
        axi_rd(`REG_CMD, {`RESP_OKAY, 32'h0});
        axi_rd(`REG_STATUS, {`RESP_OKAY, 32'h0001_0000});
        rnd = $random(seed);
        axi_wr(8'h0C, rnd, 4'hF, `RESP_SLVERR);
        axi_rd(8'h0C, {`RESP_SLVERR, 32'h0});
        for (c = 0; c < 4; c++) begin
            cfg = 2'(c);
            rnd = $random(seed);
            wait_vblank();
            axi_wr(`REG_SCAN, {rnd[31:2], cfg}, 4'hF, `RESP_OKAY);
            axi_rd(`REG_SCAN, {`RESP_OKAY, 30'h0, cfg});
            for (n = 0; n < 320; n++) begin
                il = cfg[1] ? ((n < 160) ? 2 * n : 2 * (n - 160) + 1) : n;
                gq.push_back(320'h1 << (cfg[0] ? 319 - il : il));
            end
            watch_g = 1'b1;
            wait_empty();
            watch_g = 1'b0;
        end
        axi_wr(`REG_CMD, 32'h0000_0035, 4'h3, `RESP_OKAY);
        axi_rd(`REG_CMD, {`RESP_OKAY, 32'h1});
        wait_vblank();
        tq.push_back(VB);
        watch_t = 1'b1;
        wait_empty();
        watch_t = 1'b0;
        axi_wr(`REG_CMD, 32'h0000_0135, 4'h3, `RESP_OKAY);
        axi_rd(`REG_CMD, {`RESP_OKAY, 32'h3});
        wait_vblank();
        for (n = 0; n < 320; n++) tq.push_back(HB);
        tq.push_back(VB - 1);
        watch_t = 1'b1;
        wait_empty();
        watch_t = 1'b0;
        axi_wr(`REG_CMD, 32'h0000_0036, 4'h3, `RESP_OKAY);
        axi_wr(`REG_CMD, 32'h0000_0035, 4'h1, `RESP_OKAY);
        axi_rd(`REG_CMD, {`RESP_OKAY, 32'h3});
        axi_wr(`REG_CMD, 32'h0000_0034, 4'h1, `RESP_OKAY);
        axi_rd(`REG_CMD, {`RESP_OKAY, 32'h2});
        repeat (3) @(posedge i_clk);
        il = 0;
        for (n = 0; n < 7000; n++) begin
            @(posedge i_clk);
            il += int'(tear === 1'b1 || write_ok === 1'b1);
        end
        check("tear_off_high", 320'h0, 320'(il));
        test_done();
    end
endmodule
